// *** verilog/zxd_pkg.sv ***
package zxd_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] CTRL_IDX = 8'h00;
    localparam logic [7:0] RSVD_IDX = 8'h01;
    localparam logic [7:0] EDGE_IDX = 8'h02;
    localparam logic [7:0] STAT_IDX = 8'h03;
    localparam logic [7:0] MASK_IDX = 8'h04;

    // detector_control field positions
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_INV_BIT     = 3;
    localparam int CTRL_PIN_OUTPUT_ENABLE_BIT   = 6;
    localparam int CTRL_RUNSTBY_BIT = 7;
    localparam logic [7:0] CTRL_WMASK = 8'hC9;

    // detector_status and mask field positions
    localparam int STAT_FLAG_BIT  = 0;
    localparam int STAT_LEVEL_BIT = 4;
    localparam int MASK_FLAG_BIT  = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] EDGE_RST = 2'h0;
    localparam logic       MASK_RST = 1'b1;

    // level synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        EDGE_NONE    = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } zxd_edge_type;

    typedef enum logic [1:0] {
        SLP_ACTIVE  = 2'b00,
        SLP_IDLE    = 2'b01,
        SLP_STANDBY = 2'b10,
        SLP_PDOWN   = 2'b11
    } zxd_sleep_type;

endpackage

// *** verilog/zxd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module zxd_sync #(
    parameter int STAGES = 3
) (
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    input  wire logic async_i,
    output logic      sync_o
);

    // a chain shorter than two is no synchroniser
    if (STAGES < 2) begin : g_bad_depth
        $error("zxd_sync: STAGES must be at least 2");
    end

    logic [STAGES-1:0] chain_ff;

    // only stage 0 sees the raw input; nothing else reads it
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            chain_ff <= '0;
        end else begin
            chain_ff <= {chain_ff[STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain_ff[STAGES-1];

endmodule

`default_nettype wire

// *** verilog/zxd_top.sv ***
// What this block does
// - one level event output tracks comparator level unsynchronised; no event inputs.
// - configured crossing sets the cross flag in the status register.
// - interrupt request high while source enabled, edge select not none and cross flag set.
// - edge select 0 none, 1 rising, 2 falling, 3 both edges.
// - control bit 3 inverts detector output for status, event and edges.
// - control bit 0 enables detector; cleared keeps output and flagging idle.
// - control bit 6 routes detector output to the pin, else pin undriven.
// - idle sleep changes nothing; detector keeps running.
// - standby disables detector unless run in standby bit 7 set.
// - power down disables detector and pin output regardless of bit 7.
// - status bit 4 is detector level after three synchroniser stages.
// - writing one to status bit 0 clears cross flag; zero ignored.
// - without inversion, level bit is one above reference, zero below.
// - inversion also swaps which transitions count as rising or falling.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module zxd_top
    import zxd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 srst_i,
    // apb slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [ADDR_W-1:0]    paddr_i,
    input  wire logic [31:0]          pwdata_i,
    input  wire logic [3:0]           pstrb_i,
    output logic                      pready_o,
    output logic [31:0]               prdata_o,
    output logic                      pslverr_o,
    // comparator and power manager
    input  wire logic                 comp_level_i,
    input  wire zxd_pkg::zxd_sleep_type sleep_mode_i,
    output logic                      comp_enable_o,
    // event, pin and interrupt
    output logic                      event_level_o,
    output logic                      pin_out_o,
    output logic                      pin_oe_o,
    output logic                      irq_o
);

    import zxd_pkg::*;

    // the map needs index 4, i.e. byte address 0x10
    if (ADDR_W < 5) begin : g_bad_addr
        $error("zxd_top: ADDR_W must be at least 5");
    end

    typedef struct packed {
        logic [7:0]   ctrl;
        zxd_edge_type edge_sel;
        logic         cross_flag;
        logic         irq_mask;
        logic         level_prev;
        logic         pready;
        logic [31:0]  prdata;
        logic         pslverr;
        logic         irq;
    } zxd_state_type;

    zxd_state_type st_ff;
    zxd_state_type nxt_st;

    logic det_active;
    logic raw_out;
    logic sync_level;
    logic level_now;
    logic rise_hit;
    logic fall_hit;
    logic edge_hit;
    logic acc_done;
    logic wr_en;
    logic [7:0] acc_idx;
    logic [7:0] rd_byte;
    logic idx_ok;

    // register index from a byte address; shared by read and write paths
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] shifted;
        shifted = addr >> 2;
        return 8'(shifted);
    endfunction

    // true when the selected edge mode fires on the given transitions
    function automatic logic mode_fires(input zxd_edge_type mode,
                                        input logic rise,
                                        input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            EDGE_NONE:    hit = 1'b0;
            EDGE_RISING:  hit = rise;
            EDGE_FALLING: hit = fall;
            EDGE_BOTH:    hit = rise | fall;
        endcase
        return hit;
    endfunction

    // sleep gating: idle runs as active, standby only with the run bit
    always_comb begin
        det_active = 1'b0;
        unique case (sleep_mode_i)
            SLP_ACTIVE:  det_active = st_ff.ctrl[CTRL_EN_BIT];
            SLP_IDLE:    det_active = st_ff.ctrl[CTRL_EN_BIT];
            SLP_STANDBY: det_active = st_ff.ctrl[CTRL_EN_BIT]
                                    & st_ff.ctrl[CTRL_RUNSTBY_BIT];
            SLP_PDOWN:   det_active = 1'b0;
        endcase
    end

    // event path stays unclocked so it works with the clock stopped
    assign raw_out = det_active & (comp_level_i ^ st_ff.ctrl[CTRL_INV_BIT]);
    assign event_level_o = raw_out;
    assign pin_out_o     = raw_out & st_ff.ctrl[CTRL_PIN_OUTPUT_ENABLE_BIT];
    assign pin_oe_o      = det_active & st_ff.ctrl[CTRL_PIN_OUTPUT_ENABLE_BIT];
    assign comp_enable_o = det_active;

    // raw comparator synchronised before any clocked logic looks at it
    zxd_sync #(
        .STAGES   (SYNC_STAGES)
    ) u_level_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .async_i   (comp_level_i),
        .sync_o    (sync_level)
    );

    // inversion applied after the chain so the status lag stays three cycles
    assign level_now = det_active & (sync_level ^ st_ff.ctrl[CTRL_INV_BIT]);

    // edges on the inverted level, so inversion swaps rising and falling
    assign rise_hit = level_now & ~st_ff.level_prev;
    assign fall_hit = ~level_now & st_ff.level_prev;
    assign edge_hit = det_active & mode_fires(st_ff.edge_sel, rise_hit, fall_hit);

    // apb: pready rises one cycle into the access phase
    assign acc_idx  = reg_index(paddr_i);
    assign acc_done = psel_i & penable_i & st_ff.pready;
    assign wr_en    = acc_done & pwrite_i & ~nxt_st_err_unused(acc_idx) & pstrb_i[0];

    // unmapped addresses answer with pslverr
    function automatic logic nxt_st_err_unused(input logic [7:0] idx);
        return idx > MASK_IDX;
    endfunction

    assign idx_ok = ~nxt_st_err_unused(acc_idx);

    // read mux; reserved and unused bits read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (acc_idx)
            CTRL_IDX: rd_byte = st_ff.ctrl;
            EDGE_IDX: rd_byte = {6'h00, st_ff.edge_sel};
            STAT_IDX: begin
                rd_byte[STAT_LEVEL_BIT] = level_now;
                rd_byte[STAT_FLAG_BIT]  = st_ff.cross_flag;
            end
            MASK_IDX: rd_byte[MASK_FLAG_BIT] = st_ff.irq_mask;
            default:  rd_byte = 8'h00;
        endcase
    end

    // next state of every register in one place
    always_comb begin
        nxt_st = st_ff;
        nxt_st.level_prev = level_now;

        // handshake: hold pready until the completing edge, then drop it
        if (acc_done) begin
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
        end else if (psel_i & penable_i) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = ~idx_ok;
            nxt_st.prdata  = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end

        // register writes take effect on the completing edge only
        if (wr_en) begin
            unique case (acc_idx)
                CTRL_IDX: nxt_st.ctrl = pwdata_i[7:0] & CTRL_WMASK;
                EDGE_IDX: nxt_st.edge_sel = zxd_edge_type'(pwdata_i[1:0]);
                MASK_IDX: nxt_st.irq_mask = pwdata_i[MASK_FLAG_BIT];
                default:  nxt_st.ctrl = st_ff.ctrl;
            endcase
        end

        // write one clears, zero ignored; a same-cycle edge wins
        if (wr_en && acc_idx == STAT_IDX && pwdata_i[STAT_FLAG_BIT]) begin
            nxt_st.cross_flag = 1'b0;
        end
        if (edge_hit) begin
            nxt_st.cross_flag = 1'b1;
        end

        // request follows flag, mask and a non-none edge mode
        nxt_st.irq = nxt_st.cross_flag & nxt_st.irq_mask
                   & (nxt_st.edge_sel != EDGE_NONE);
    end

    // single state register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_ff            <= '0;
            st_ff.ctrl       <= CTRL_RST;
            st_ff.edge_sel   <= zxd_edge_type'(EDGE_RST);
            st_ff.irq_mask   <= MASK_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pready_o  = st_ff.pready;
    assign prdata_o  = st_ff.prdata;
    assign pslverr_o = st_ff.pslverr;
    assign irq_o     = st_ff.irq;

endmodule

`default_nettype wire

// *** testbench/zxd_comp_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module zxd_comp_model (
    input  wire logic above_i,
    output logic      level_o
);
    // output lags the crossing so it lands off the clock edge
    always @(above_i) begin
        level_o <= #37 above_i;
    end
    initial begin
        level_o = 1'b0;
    end
endmodule
`default_nettype wire

// *** testbench/zxd_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module zxd_top_chk
    import zxd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic                   ref_clk_i,
    input wire logic                   srst_i,
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire logic [ADDR_W-1:0]      paddr_i,
    input wire logic [31:0]            pwdata_i,
    input wire logic [3:0]             pstrb_i,
    input wire logic                   pready_o,
    input wire logic [31:0]            prdata_o,
    input wire logic                   pslverr_o,
    input wire logic                   comp_level_i,
    input wire zxd_pkg::zxd_sleep_type sleep_mode_i,
    input wire logic                   comp_enable_o,
    input wire logic                   event_level_o,
    input wire logic                   pin_out_o,
    input wire logic                   pin_oe_o,
    input wire logic                   irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // outputs of a stopped detector stay low
    a_event_off: assert property (!comp_enable_o |-> !event_level_o)
        else $error("event high while detector off");
    a_pin_off: assert property (!pin_oe_o |-> !pin_out_o)
        else $error("pin data without enable");
    a_pin_follow: assert property (pin_oe_o |-> pin_out_o == event_level_o)
        else $error("pin differs from event level");
    a_pdown_off: assert property (sleep_mode_i == SLP_PDOWN |-> !comp_enable_o && !pin_oe_o)
        else $error("detector alive in power down");
    // idle entry without a register write must not change the detector enable
    a_idle_same: assert property ($past(sleep_mode_i) == SLP_ACTIVE && sleep_mode_i == SLP_IDLE
        && !$past(pready_o) |-> $stable(comp_enable_o))
        else $error("idle changed detector state");
    // irq may only drop around a completed write
    a_irq_hold: assert property (irq_o && !pready_o && !$past(pready_o) |=> irq_o)
        else $error("irq dropped without a write");
    // bus answers: one-cycle ready, reserved word reads zero
    a_ready_after: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_rsvd_zero: assert property (pready_o && !pwrite_i && (paddr_i >> 2) == ADDR_W'(1)
        |-> prdata_o == 32'h0)
        else $error("reserved word not zero");
endmodule
bind zxd_top zxd_top_chk #(.ADDR_W(ADDR_W)) u_zxd_top_chk (.*);
`default_nettype wire

// *** testbench/test_zero_cross_detect_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_zero_cross_detect_control;
    import zxd_pkg::*;
    logic          clk, rst, psel, pen, pwr, rdy, err, e, above, lvl, en, ev, po, poe, irq;
    logic [7:0]    padr;
    logic [31:0]   pwd, prd, r;
    zxd_sleep_type slp;
    int            failures, checks;
    zxd_top u_zxd_top (.ref_clk_i(clk), .srst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hF), .pready_o(rdy),
        .prdata_o(prd), .pslverr_o(err), .comp_level_i(lvl), .sleep_mode_i(slp),
        .comp_enable_o(en), .event_level_o(ev), .pin_out_o(po), .pin_oe_o(poe), .irq_o(irq));
    zxd_comp_model u_zxd_comp_model (.above_i(above), .level_o(lvl));
    // one apb transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= i << 2;
        pwd  <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        // look at ready mid-cycle, where it has settled, then finish on the next edge
        do @(negedge clk); while (rdy !== 1'b1);
        r = prd;
        e = err;
        @(posedge clk);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, s, x);
        end
    endtask
    // move the waveform, then let the synchroniser settle
    task automatic step(input logic a);
        @(posedge clk);
        above <= a;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_regs;
        apb(1'b0, CTRL_IDX, 8'h00);
        chk(r, 32'h0);
        apb(1'b0, STAT_IDX, 8'h00);
        chk(r, 32'h0);
        apb(1'b0, MASK_IDX, 8'h00);
        chk(r, 32'h1);
        apb(1'b1, CTRL_IDX, 8'hFF);
        apb(1'b0, CTRL_IDX, 8'h00);
        chk(r, 32'hC9);
        apb(1'b1, RSVD_IDX, 8'hFF);
        apb(1'b0, RSVD_IDX, 8'h00);
        chk(r, 32'h0);
        apb(1'b0, 8'h05, 8'h00);
        chk(e, 1'b1);
        $display("regs done");
    endtask
    // every edge mode, with and without inversion
    task automatic t_edges;
        logic [1:0] m;
        logic       v;
        for (int k = 0; k < 8; k++) begin
            m = k[1:0];
            v = k[2];
            apb(1'b1, CTRL_IDX, {4'h0, v, 3'h1});
            apb(1'b1, EDGE_IDX, {6'h0, m});
            step(1'b0);
            apb(1'b1, STAT_IDX, 8'h01);
            step(1'b1);
            apb(1'b0, STAT_IDX, 8'h00);
            chk(r, {27'h0, ~v, 3'h0, v ? m[1] : m[0]});
            chk(irq, v ? m[1] : m[0]);
            apb(1'b1, STAT_IDX, 8'h01);
            step(1'b0);
            apb(1'b0, STAT_IDX, 8'h00);
            chk(r, {27'h0, v, 3'h0, v ? m[0] : m[1]});
        end
        $display("edges done");
    endtask
    // masked flag, ignored zero write, then clear
    task automatic t_mask;
        apb(1'b1, STAT_IDX, 8'h01);
        apb(1'b1, MASK_IDX, 8'h00);
        step(1'b1);
        chk(irq, 1'b0);
        apb(1'b1, STAT_IDX, 8'h00);
        apb(1'b1, MASK_IDX, 8'h01);
        apb(1'b0, STAT_IDX, 8'h00);
        chk(r[0], 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, STAT_IDX, 8'h01);
        apb(1'b0, STAT_IDX, 8'h00);
        chk(r[0], 1'b0);
        chk(irq, 1'b0);
        $display("mask done");
    endtask
    // waveform held high, no inversion
    task automatic sl(input logic [7:0] c, input zxd_sleep_type s, input logic x);
        apb(1'b1, CTRL_IDX, c);
        @(posedge clk);
        slp <= s;
        repeat (2) @(posedge clk);
        chk(en, x);
        chk(ev, x);
        chk(poe, x & c[6]);
        chk(po, x & c[6]);
    endtask
    task automatic t_sleep;
        sl(8'hC1, SLP_ACTIVE, 1'b1);
        sl(8'hC1, SLP_IDLE, 1'b1);
        sl(8'hC1, SLP_STANDBY, 1'b1);
        sl(8'h41, SLP_STANDBY, 1'b0);
        sl(8'hC1, SLP_PDOWN, 1'b0);
        sl(8'h81, SLP_ACTIVE, 1'b1);
        sl(8'h00, SLP_ACTIVE, 1'b0);
        $display("sleep done");
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out;
    end
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, above} = 4'h0;
        padr = 8'h00;
        pwd = 32'h0;
        slp = SLP_ACTIVE;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_edges;
        t_mask;
        t_sleep;
        close_out;
    end
endmodule
`default_nettype wire
